// >>> rtl/tca_pkg.sv
// Constants, register map and state type of the temperature conversion and alert controller
package tca_pkg;

    // Clock and timing
    localparam int          CLK_MHZ          = 100;
    localparam int          CYCLE_BASE_US    = 16000;
    localparam int          CYCLE_BASE_CYC   = CYCLE_BASE_US * CLK_MHZ;

    // Register byte addresses
    localparam logic [7:0]  ADDR_RESULT      = 8'h00;
    localparam logic [7:0]  ADDR_CONFIG      = 8'h04;
    localparam logic [7:0]  ADDR_HIGH        = 8'h08;
    localparam logic [7:0]  ADDR_LOW         = 8'h0C;
    localparam logic [7:0]  ADDR_ALERT_RESP  = 8'h10;
    localparam logic [7:0]  ADDR_STATE       = 8'h14;

    // Configuration register field positions
    localparam int          CFG_OVER         = 15;
    localparam int          CFG_UNDER        = 14;
    localparam int          CFG_READY        = 13;
    localparam int          CFG_MODE_LSB     = 10;
    localparam int          CFG_CYCLE_LSB    = 7;
    localparam int          CFG_AVG_LSB      = 5;
    localparam int          CFG_HYST         = 4;
    localparam int          CFG_POL          = 3;
    localparam int          CFG_RDYPIN       = 2;

    // Values after reset
    localparam logic [15:0] RESULT_RST       = 16'h8000;
    localparam logic [15:0] HIGH_RST         = 16'h3000;
    localparam logic [15:0] LOW_RST          = 16'h8000;
    localparam logic [2:0]  CYCLE_RST        = 3'h4;
    localparam logic [1:0]  AVG_RST          = 2'h1;

    // Conversion mode codes
    localparam logic [1:0]  MODE_CONT_A      = 2'h0;
    localparam logic [1:0]  MODE_OFF         = 2'h1;
    localparam logic [1:0]  MODE_CONT_B      = 2'h2;
    localparam logic [1:0]  MODE_SINGLE      = 2'h3;

    typedef enum logic [2:0] {
        TCA_OFF     = 3'b001,
        TCA_ACTIVE  = 3'b010,
        TCA_STANDBY = 3'b100
    } tca_state_t;

endpackage

// >>> rtl/tca_ctrl.sv
// Conversion sequencer, result and limit flags, alert pin, Wishbone register slave
//
// Behaviour
// - Each finished conversion writes 16-bit signed result
// - Limits use the same signed temperature code
// - Modes 00 and 10 convert continuously once written; not from start-up
// - Config or result read clears ready flag
// - Ready-on-pin select drives pin from ready
// - Continuous cycle: active period then standby
// - Writing mode 01 aborts into shutdown
// - Mode 11: one conversion, then shutdown
// - Single conversion end sets ready and flags
// - Start-up single mode becomes shutdown
// - Compare final averaged result against limits
// - Window mode: over and under flags set
// - Window mode: config read clears flags
// - Window mode pin: asserted until read/response
// - Pin active level follows polarity select
// - Hysteresis: set above high, clear below low
// - Hysteresis: under zero, reads keep flags
// - Hysteresis: pin mirrors over flag only
// - Result reads minus 256 before first conversion
// - Averaging 01 averages eight samples
`timescale 1ns/1ps

module tca_ctrl #(
    parameter int CYCLE_BASE_CYC = tca_pkg::CYCLE_BASE_CYC
) (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic [1:0]  STARTUP_MODE,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic             SAMPLE_REQ,
    input  wire logic        SAMPLE_VALID,
    input  wire logic [15:0] SAMPLE_DATA,
    output logic             ALERT
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [2:0] avg_shift(input logic [1:0] sel);
        case (sel)
            2'h0:    avg_shift = 3'h0;
            2'h1:    avg_shift = 3'h3;
            2'h2:    avg_shift = 3'h5;
            default: avg_shift = 3'h6;
        endcase
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
        merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    tca_pkg::tca_state_t state;
    tca_pkg::tca_state_t next_state;
    logic        [15:0] result;
    logic        [15:0] high_lim;
    logic        [15:0] low_lim;
    logic        [1:0]  conv_mode_sel;
    logic        [2:0]  cycle_time_sel;
    logic        [1:0]  avg_count_sel;
    logic               hysteresis_mode_sel;
    logic               pin_polarity_sel;
    logic               ready_on_pin_sel;
    logic               ready;
    logic               over;
    logic               under;
    logic               win_alert;
    logic               single;
    logic        [5:0]  samp_cnt;
    logic signed [21:0] acc;
    logic        [31:0] cyc_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    wire        bus_req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    wire        bus_wr    = bus_req & WB_WE_I;
    wire        bus_rd    = bus_req & ~WB_WE_I;
    wire        cfg_sel   = WB_ADR_I == tca_pkg::ADDR_CONFIG;
    wire        cfg_rd    = bus_rd & cfg_sel;
    wire        res_rd    = bus_rd & (WB_ADR_I == tca_pkg::ADDR_RESULT);
    wire        cfg_wr    = bus_wr & cfg_sel;
    wire        hi_wr     = bus_wr & (WB_ADR_I == tca_pkg::ADDR_HIGH);
    wire        lo_wr     = bus_wr & (WB_ADR_I == tca_pkg::ADDR_LOW);
    wire        resp_wr   = bus_wr & (WB_ADR_I == tca_pkg::ADDR_ALERT_RESP);
    wire [15:0] cfg_new   = merge16(16'h0000, WB_DAT_I, WB_SEL_I);
    wire        mode_wr   = cfg_wr & WB_SEL_I[1];
    wire [1:0]  new_mode  = cfg_new[tca_pkg::CFG_MODE_LSB +: 2];
    wire        abort     = mode_wr & (new_mode == tca_pkg::MODE_OFF);
    wire        ctl_lo_wr = cfg_wr & WB_SEL_I[0];

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencing and averaging

    wire [2:0]         shift     = avg_shift(avg_count_sel);
    wire [5:0]         last_samp = 6'((7'h01 << shift) - 7'h01);
    wire signed [21:0] acc_sum   = acc + 22'(signed'(SAMPLE_DATA));
    wire signed [21:0] acc_avg   = acc_sum >>> shift;
    wire [15:0]        avg_value = acc_avg[15:0];
    wire               samp_take = (state == tca_pkg::TCA_ACTIVE) & SAMPLE_VALID;
    // Catch-up compare: a shrunk averaging setting cannot strand the count
    wire               conv_done = samp_take & (samp_cnt >= last_samp);
    wire               done_ok   = conv_done & ~abort;
    wire [31:0]        period    = 32'(CYCLE_BASE_CYC) << cycle_time_sel;
    wire               cycle_end = cyc_cnt >= period - 32'h0000_0001;

    always_comb begin
        next_state = state;
        if (abort) begin
            next_state = tca_pkg::TCA_OFF;
        end else if (mode_wr && state == tca_pkg::TCA_OFF) begin
            next_state = tca_pkg::TCA_ACTIVE;
        end else begin
            case (state)
                tca_pkg::TCA_ACTIVE: begin
                    if (done_ok) begin
                        next_state = single ? tca_pkg::TCA_OFF : tca_pkg::TCA_STANDBY;
                    end
                end
                tca_pkg::TCA_STANDBY: begin
                    if (cycle_end) begin
                        next_state = tca_pkg::TCA_ACTIVE;
                    end
                end
                tca_pkg::TCA_OFF: begin
                    next_state = tca_pkg::TCA_OFF;
                end
                default: begin
                    next_state = tca_pkg::TCA_OFF;
                end
            endcase
        end
    end

    // Averaging restarts whenever the active period is entered afresh
    wire restart = next_state == tca_pkg::TCA_ACTIVE && state != tca_pkg::TCA_ACTIVE;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state    <= tca_pkg::TCA_OFF;
            samp_cnt <= 6'h00;
            acc      <= 22'h00_0000;
            cyc_cnt  <= 32'h0000_0000;
        end else begin
            state    <= next_state;
            samp_cnt <= (restart || conv_done) ? 6'h00 : samp_cnt + 6'(samp_take);
            acc      <= (restart || conv_done) ? 22'h00_0000 : (samp_take ? acc_sum : acc);
            cyc_cnt  <= restart ? 32'h0000_0000 : cyc_cnt + 32'h0000_0001;
        end
    end

    // Start-up mode is taken from the loader at reset; a single-shot start is refused
    wire [1:0] start_mode = (STARTUP_MODE == tca_pkg::MODE_SINGLE) ? tca_pkg::MODE_OFF : STARTUP_MODE;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration, limits, result

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            conv_mode_sel       <= start_mode;
            single              <= 1'b0;
            cycle_time_sel      <= tca_pkg::CYCLE_RST;
            avg_count_sel       <= tca_pkg::AVG_RST;
            hysteresis_mode_sel <= 1'b0;
            pin_polarity_sel    <= 1'b0;
            ready_on_pin_sel    <= 1'b0;
            high_lim            <= tca_pkg::HIGH_RST;
            low_lim             <= tca_pkg::LOW_RST;
            result              <= tca_pkg::RESULT_RST;
        end else begin
            if (mode_wr) begin
                conv_mode_sel  <= new_mode;
                cycle_time_sel <= cfg_new[tca_pkg::CFG_CYCLE_LSB +: 3];
                single         <= new_mode == tca_pkg::MODE_SINGLE;
            end else if (done_ok && single) begin
                conv_mode_sel  <= tca_pkg::MODE_OFF;
                single         <= 1'b0;
            end
            if (ctl_lo_wr) begin
                avg_count_sel       <= cfg_new[tca_pkg::CFG_AVG_LSB +: 2];
                hysteresis_mode_sel <= cfg_new[tca_pkg::CFG_HYST];
                pin_polarity_sel    <= cfg_new[tca_pkg::CFG_POL];
                ready_on_pin_sel    <= cfg_new[tca_pkg::CFG_RDYPIN];
            end
            if (hi_wr) begin
                high_lim <= merge16(high_lim, WB_DAT_I, WB_SEL_I);
            end
            if (lo_wr) begin
                low_lim <= merge16(low_lim, WB_DAT_I, WB_SEL_I);
            end
            if (done_ok) begin
                result <= avg_value;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags and alert pin

    wire is_gt = $signed(avg_value) > $signed(high_lim);
    wire is_lt = $signed(avg_value) < $signed(low_lim);
    wire hyst  = hysteresis_mode_sel;

    // Set always wins over a clear in the same cycle
    wire next_ready = done_ok | (ready & ~(cfg_rd | res_rd));
    wire win_over   = (done_ok & is_gt) | (over & ~cfg_rd);
    wire hys_over   = done_ok ? (is_gt | (over & ~is_lt)) : over;
    wire next_over  = hyst ? hys_over : win_over;
    wire next_under = ~hyst & ((done_ok & is_lt) | (under & ~cfg_rd));
    wire win_set    = done_ok & (is_gt | is_lt);
    wire next_win   = win_set | (win_alert & ~(cfg_rd | resp_wr));
    wire pin_level  = ready_on_pin_sel ? next_ready : (hyst ? next_over : next_win);
    // Polarity written this cycle applies at once, so a write never pulses the pin
    wire next_pol   = ctl_lo_wr ? cfg_new[tca_pkg::CFG_POL] : pin_polarity_sel;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ready     <= 1'b0;
            over      <= 1'b0;
            under     <= 1'b0;
            win_alert <= 1'b0;
            ALERT     <= 1'b1;                                                  // Inactive for reset polarity
        end else begin
            ready     <= next_ready;
            over      <= next_over;
            under     <= next_under;
            win_alert <= next_win;
            ALERT     <= ~(pin_level ^ next_pol);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read-back and bus answer

    wire [15:0] cfg_word = {over, under, ready, 1'b0, conv_mode_sel, cycle_time_sel, avg_count_sel,
                            hysteresis_mode_sel, pin_polarity_sel, ready_on_pin_sel, 2'h0};
    wire [15:0] rd_word  = (WB_ADR_I == tca_pkg::ADDR_RESULT) ? result :
                           cfg_sel                              ? cfg_word :
                           (WB_ADR_I == tca_pkg::ADDR_HIGH)     ? high_lim :
                           (WB_ADR_I == tca_pkg::ADDR_LOW)      ? low_lim :
                           (WB_ADR_I == tca_pkg::ADDR_STATE)    ? {7'h00, state, samp_cnt} :
                                                                  16'h0000;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            WB_ACK_O   <= 1'b0;
            WB_DAT_O   <= 32'h0000_0000;
            SAMPLE_REQ <= 1'b0;
        end else begin
            WB_ACK_O   <= bus_req;
            WB_DAT_O   <= bus_rd ? {16'h0000, rd_word} : 32'h0000_0000;
            SAMPLE_REQ <= next_state == tca_pkg::TCA_ACTIVE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    // Bus answer: one-cycle ack, data only with it
    a_ack_take: assert property (bus_req |=> WB_ACK_O)
        else $error("request not acknowledged next cycle");

    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held for two cycles");

    a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
        else $error("read data driven outside an ack");

    // Sequencing
    a_state_onehot: assert property ($onehot(state))
        else $error("sequencer state not one-hot");

    a_req_state: assert property (SAMPLE_REQ == (state == tca_pkg::TCA_ACTIVE))
        else $error("sample request out of step with state");

    a_cycle_end: assert property (
        state == tca_pkg::TCA_STANDBY && cycle_end && !abort |=> state == tca_pkg::TCA_ACTIVE)
        else $error("standby did not end with the cycle period");

    a_count_restart: assert property (restart |=> samp_cnt == 6'h00)
        else $error("sample count not cleared at conversion start");

    a_abort_off: assert property (abort |=> state == tca_pkg::TCA_OFF && !SAMPLE_REQ)
        else $error("shutdown write did not abort");

    a_off_stays: assert property (
        state == tca_pkg::TCA_OFF && !mode_wr |=> state == tca_pkg::TCA_OFF)
        else $error("shutdown left without a mode write");

    a_single_end: assert property (
        done_ok && single |=> state == tca_pkg::TCA_OFF && conv_mode_sel == tca_pkg::MODE_OFF && ready)
        else $error("single conversion did not end in shutdown");

    // Result register
    a_result_update: assert property (done_ok |=> result == $past(avg_value))
        else $error("result not updated at conversion end");

    a_result_hold: assert property (!done_ok |=> $stable(result))
        else $error("result changed outside conversion end");

    a_reset_result: assert property (@(posedge CLK) disable iff (1'b0)
        SYS_RST |=> result == tca_pkg::RESULT_RST)
        else $error("result not minus 256 after reset");

    // Ready flag
    a_ready_set: assert property (done_ok |=> ready)
        else $error("ready not set at conversion end");

    a_ready_clear: assert property ((res_rd || cfg_rd) && !done_ok |=> !ready)
        else $error("ready not cleared by read");

    a_ready_hold: assert property (!ready && !done_ok |=> !ready)
        else $error("ready set without a conversion");

    // Limit flags
    a_window_over: assert property (!hyst && done_ok && is_gt |=> over)
        else $error("over flag not set above high limit");

    a_window_under: assert property (!hyst && done_ok && is_lt |=> under)
        else $error("under flag not set below low limit");

    a_window_clear: assert property (!hyst && cfg_rd && !done_ok && !cfg_wr |=> !over && !under)
        else $error("window flags survived config read");

    a_hyst_hold: assert property (hyst && !done_ok && !ctl_lo_wr |=> $stable(over) && !under)
        else $error("hysteresis flags changed outside conversion end");

    a_hyst_under: assert property (hyst |=> !under)
        else $error("under flag set in hysteresis mode");

    a_hyst_set: assert property (hyst && done_ok && is_gt |=> over)
        else $error("hysteresis flag not set above high limit");

    a_hyst_release: assert property (hyst && done_ok && is_lt && !is_gt |=> !over)
        else $error("hysteresis flag not cleared below low limit");

    // Alert latch and pin
    a_window_latch: assert property (!hyst && done_ok && (is_gt || is_lt) |=> win_alert)
        else $error("window latch not set on a crossing");

    a_window_free: assert property (!hyst && (cfg_rd || resp_wr) && !done_ok |=> !win_alert)
        else $error("window latch not released");

    a_pin_reset: assert property (@(posedge CLK) disable iff (1'b0) SYS_RST |=> ALERT)
        else $error("alert pin active during reset");

    a_pin_ready: assert property (
        ready_on_pin_sel |=> ALERT == (ready ~^ pin_polarity_sel))
        else $error("alert pin not following ready flag");

    a_pin_hyst: assert property (
        !ready_on_pin_sel && hyst |=> ALERT == (over ~^ pin_polarity_sel))
        else $error("alert pin not following over flag");

    a_pin_window: assert property (
        !ready_on_pin_sel && !hyst |=> ALERT == (win_alert ~^ pin_polarity_sel))
        else $error("alert pin not following window latch");

endmodule

// >>> tb/tca_conv_model.sv
// Converter stand-in: answers sample requests with a ramp
`timescale 1ns/1ps

module tca_conv_model (
    input  wire logic        clk,
    input  wire logic        req,
    input  wire logic [15:0] temp,
    output logic             valid,
    output logic      [15:0] data
);
    logic [1:0]  gap = 2'h0;
    logic [15:0] idx = 16'h0000;

    initial begin
        valid = 1'b0;
        data  = 16'h0000;
    end

    // Ramp temp+idx exposes a wrong average count
    // Data flips each idle cycle so a stale sample cannot pass
    always @(posedge clk) begin
        valid <= 1'b0;
        data  <= ~data;
        if (!req) begin
            gap <= 2'h0;
            idx <= 16'h0000;
        end else if (gap == 2'h3) begin
            valid <= 1'b1;
            data  <= temp + idx;
            idx   <= idx + 16'h0001;
            gap   <= 2'h0;
        end else begin
            gap <= gap + 2'h1;
        end
    end
endmodule

// >>> tb/tca_ctrl_tb.sv
// Self-checking bench for the conversion and alert controller
`timescale 1ns/1ps

module tca_ctrl_tb;
    localparam int BASE = 50;
    logic        clk;
    logic        sys_rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic        ack;
    logic        req;
    logic        valid;
    logic        alert;
    logic [15:0] sdata;
    logic [15:0] temp;
    logic [1:0]  smode;
    time         t0;
    int          failures;
    int          checks;

    tca_ctrl #(.CYCLE_BASE_CYC(BASE)) tca_ctrl_inst (
        .CLK(clk), .SYS_RST(sys_rst), .STARTUP_MODE(smode), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .SAMPLE_REQ(req), .SAMPLE_VALID(valid), .SAMPLE_DATA(sdata), .ALERT(alert)
    );

    tca_conv_model tca_conv_model_inst (
        .clk(clk), .req(req), .temp(temp), .valid(valid), .data(sdata)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Request held until ack is sampled high, then released at the next edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc   <= 1'h1;
        stb   <= 1'h1;
        we    <= w;
        adr   <= a;
        dat_i <= d;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (ack !== 1'h1 && n < 50);
        if (n >= 50) failures++;
        rd = dat_o;
        @(posedge clk);
        cyc <= 1'h0;
        stb <= 1'h0;
        #1;
    endtask

    task automatic wait_pin(input logic lvl);
        int n;
        n = 0;
        while (alert !== lvl && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(alert, lvl, "pin wait");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        wb(1'h0, tca_pkg::ADDR_RESULT, 32'h0000_0000);
        check(rd, 32'h0000_8000, "result at reset");
        check(alert, 1'h1, "pin idle after reset");
        wb(1'h0, tca_pkg::ADDR_CONFIG, 32'h0000_0000);
        check(rd, 32'h0000_0620, "config at reset");
        wb(1'h0, tca_pkg::ADDR_HIGH, 32'h0000_0000);
        check(rd, 32'h0000_3000, "high at reset");
        wb(1'h0, 8'h20, 32'h0000_0000);
        check(rd, 32'h0000_0000, "unmapped read");
        check(req, 1'h0, "idle after start");
    endtask

    task automatic t_single();
        temp <= 16'h3200;
        wb(1'h1, tca_pkg::ADDR_LOW, 32'h0000_F380);
        wb(1'h1, tca_pkg::ADDR_HIGH, 32'h0000_0C80);
        wb(1'h1, tca_pkg::ADDR_CONFIG, 32'h0000_0E08);
        wait_pin(1'h1);
        wb(1'h0, tca_pkg::ADDR_CONFIG, 32'h0000_0000);
        check(rd, 32'h0000_A608, "single end");
        check(alert, 1'h0, "read frees pin");
        wb(1'h0, tca_pkg::ADDR_CONFIG, 32'h0000_0000);
        check(rd, 32'h0000_0608, "flags cleared");
        wb(1'h0, tca_pkg::ADDR_RESULT, 32'h0000_0000);
        check(rd, 32'h0000_3200, "single result");
    endtask

    // Ramp F37C..F383 averages to F37F, one below the low limit
    task automatic t_avg();
        temp <= 16'hF37C;
        wb(1'h1, tca_pkg::ADDR_CONFIG, 32'h0000_0E28);
        wait_pin(1'h1);
        wb(1'h1, tca_pkg::ADDR_ALERT_RESP, 32'h0000_0001);
        check(alert, 1'h0, "alert response");
        wb(1'h0, tca_pkg::ADDR_CONFIG, 32'h0000_0000);
        check(rd, 32'h0000_6628, "under flag");
        wb(1'h0, tca_pkg::ADDR_RESULT, 32'h0000_0000);
        check(rd, 32'h0000_F37F, "eight average");
    endtask

    task automatic t_hyst();
        temp <= 16'h3200;
        wb(1'h1, tca_pkg::ADDR_CONFIG, 32'h0000_0018);
        wait_pin(1'h1);
        wb(1'h1, tca_pkg::ADDR_ALERT_RESP, 32'h0000_0001);
        wb(1'h0, tca_pkg::ADDR_CONFIG, 32'h0000_0000);
        check(rd & 32'h0000_C000, 32'h0000_8000, "hyst over");
        check(alert, 1'h1, "pin holds");
        temp <= 16'h0000;
        @(posedge req);
        t0 = $time;
        @(posedge req);
        check(32'(($time - t0) / 10), BASE, "cycle period");
        wb(1'h0, tca_pkg::ADDR_CONFIG, 32'h0000_0000);
        check(rd & 32'h0000_E000, 32'h0000_A000, "between limits");
        temp <= 16'hF000;
        wait_pin(1'h0);
        @(posedge req);
        wb(1'h1, tca_pkg::ADDR_CONFIG, 32'h0000_0418);
        check(req, 1'h0, "abort");
        wb(1'h0, tca_pkg::ADDR_STATE, 32'h0000_0000);
        check(rd & 32'h0000_01C0, 32'h0000_0040, "off state");
    endtask

    // Last continuous result is read first so a stale ready cannot hold the pin
    task automatic t_ready_pin();
        wb(1'h0, tca_pkg::ADDR_RESULT, 32'h0000_0000);
        check(rd, 32'h0000_F000, "last result");
        wb(1'h1, tca_pkg::ADDR_CONFIG, 32'h0000_0E04);
        check(alert, 1'h1, "inactive high");
        wait_pin(1'h0);
        wb(1'h0, tca_pkg::ADDR_RESULT, 32'h0000_0000);
        check(rd, 32'h0000_F000, "result");
        check(alert, 1'h1, "ready cleared");
    endtask

    // Mid-run reset with a continuous start-up mode: registers reload, nothing converts
    task automatic t_restart();
        @(posedge clk);
        smode   <= 2'h0;
        sys_rst <= 1'h1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        wb(1'h0, tca_pkg::ADDR_RESULT, 32'h0000_0000);
        check(rd, 32'h0000_8000, "result after restart");
        check(alert, 1'h1, "pin idle after restart");
        wb(1'h0, tca_pkg::ADDR_CONFIG, 32'h0000_0000);
        check(rd, 32'h0000_0220, "config after restart");
        check(req, 1'h0, "no conversion after restart");
    endtask

    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    initial begin
        sys_rst  = 1'h1;
        cyc      = 1'h0;
        stb      = 1'h0;
        we       = 1'h0;
        adr      = 8'h00;
        sel      = 4'h3;
        dat_i    = 32'h0000_0000;
        temp     = 16'h0000;
        smode    = 2'h3;
        failures = 0;
        checks   = 0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'h0;
        t_reset();
        t_single();
        t_avg();
        t_hyst();
        t_ready_pin();
        t_restart();
        finish_test();
    end

    // Whole run needs a few hundred cycles; this allows twenty thousand
    initial begin
        #200000;
        failures++;
        finish_test();
    end
endmodule
